// *** design/ssi_encoder.sv ***
// Encoder end: position processing, preset, direction and SSI shifter.
// Assumes raw_pos comes from sensor logic on pclk; link pins are async.
`timescale 1ns/100ps
`include "ssi_params.svh"
module ssi_encoder
#(
  parameter int ST_W = 14,
  parameter int MT_W = 24,
  parameter bit GRAY = 1'b1,
  parameter bit DIR_INVERT = 1'b0,
  parameter logic [63:0] PRESET_VAL = 64'h0,
  parameter int unsigned REFRESH_CYC = `SSI_REFRESH_CYC,
  parameter int unsigned SET_DELAY_CYC = `SSI_SET_DELAY_CYC,
  parameter int unsigned SET_PROC_CYC = `SSI_SET_PROC_CYC,
  parameter int unsigned DIR_RESP_CYC = `SSI_DIR_RESP_CYC,
  parameter int unsigned POWERUP_CYC = `SSI_POWERUP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  ssi_link_if.encoder link,
  input wire logic [MT_W+ST_W-1:0] raw_pos,
  output logic pos_valid,
  output logic set_busy
);
  localparam int W = MT_W + ST_W;
  localparam logic [15:0] MONO = 16'(`SSI_MONOFLOP_CYC);

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers: bit 0 clock, bit 1 preset, bit 2 direction
  logic [2:0] in_s1_q;
  logic [2:0] in_s2_q;
  logic clk_prev_q;
  logic fall;
  logic rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_s1_q <= 3'h1;
      in_s2_q <= 3'h1;
      clk_prev_q <= 1'b1;
    end
    else
    begin
      in_s1_q <= {link.dir_line, link.preset_line, link.clk_line};
      in_s2_q <= in_s1_q;
      clk_prev_q <= in_s2_q[0];
    end
  end

  assign fall = clk_prev_q & ~in_s2_q[0];
  assign rise = ~clk_prev_q & in_s2_q[0];

  ////////////////////////////////////////////////////////////////////
  // Power-up delay
  logic [31:0] pu_cnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pu_cnt_q <= 32'h0;
      pos_valid <= 1'b0;
    end
    else if (pu_cnt_q == 32'(POWERUP_CYC - 1))
    begin
      pos_valid <= 1'b1;
    end
    else
    begin
      pu_cnt_q <= pu_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Direction: steady for the response time, then applied
  logic dir_eff_q;
  logic dir_tgt;
  logic [31:0] dir_cnt_q;

  assign dir_tgt = in_s2_q[2] ^ DIR_INVERT;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_eff_q <= 1'b0;
      dir_cnt_q <= 32'h0;
    end
    else if (dir_tgt == dir_eff_q)
    begin
      dir_cnt_q <= 32'h0;
    end
    else if (dir_cnt_q == 32'(DIR_RESP_CYC - 1))
    begin
      dir_eff_q <= dir_tgt;
      dir_cnt_q <= 32'h0;
    end
    else
    begin
      dir_cnt_q <= dir_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Position arithmetic
  logic [W-1:0] counted;
  logic [W-1:0] offset_q;
  logic [W-1:0] reported;

  assign counted = dir_eff_q ? (~raw_pos + W'(1)) : raw_pos;
  assign reported = counted - offset_q;

  ////////////////////////////////////////////////////////////////////
  // Preset: input delay, then offset load and commit phase
  logic [31:0] set_cnt_q;
  logic [31:0] proc_cnt_q;
  logic set_fire;

  assign set_fire = in_s2_q[1] & ~set_busy & (set_cnt_q == 32'(SET_DELAY_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set_cnt_q <= 32'h0;
    end
    else if (!in_s2_q[1])
    begin
      set_cnt_q <= 32'h0;
    end
    else if (set_cnt_q < 32'(SET_DELAY_CYC))
    begin
      set_cnt_q <= set_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      offset_q <= '0;
    end
    else if (set_fire)
    begin
      offset_q <= counted - PRESET_VAL[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set_busy <= 1'b0;
      proc_cnt_q <= 32'h0;
    end
    else if (set_fire)
    begin
      set_busy <= 1'b1;
      proc_cnt_q <= 32'h0;
    end
    else if (set_busy)
    begin
      if (proc_cnt_q == 32'(SET_PROC_CYC - 1))
      begin
        set_busy <= 1'b0;
      end
      proc_cnt_q <= proc_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample refresh, forced right after a preset or direction change
  logic [31:0] ref_cnt_q;
  logic ref_now_q;
  logic [W-1:0] sample_q;
  logic [W-1:0] coded;

  assign coded = GRAY ? (reported ^ (reported >> 1)) : reported;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_now_q <= 1'b0;
    end
    else
    begin
      ref_now_q <= set_fire | (dir_tgt != dir_eff_q && dir_cnt_q == 32'(DIR_RESP_CYC - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_cnt_q <= 32'h0;
      sample_q <= '0;
    end
    else if (ref_now_q || ref_cnt_q == 32'(REFRESH_CYC - 1))
    begin
      ref_cnt_q <= 32'h0;
      sample_q <= coded;
    end
    else
    begin
      ref_cnt_q <= ref_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Monoflop: reloaded on every link clock edge
  logic [15:0] mono_q;
  logic expired;

  assign expired = (mono_q == 16'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mono_q <= 16'h0;
    end
    else if (fall || rise)
    begin
      mono_q <= MONO;
    end
    else if (!expired)
    begin
      mono_q <= mono_q - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shifter
  logic active_q;
  logic [W-1:0] word_q;
  logic [W-1:0] sh_q;
  logic [6:0] bit_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_q <= '0;
    end
    else if (fall && !active_q && expired)
    begin
      word_q <= sample_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_q <= 1'b0;
      sh_q <= '0;
      bit_q <= 7'h0;
    end
    else if (fall && !active_q)
    begin
      active_q <= 1'b1;
      bit_q <= 7'h0;
      sh_q <= expired ? sample_q : word_q;
    end
    else if (rise && active_q)
    begin
      if (bit_q == 7'(W))
      begin
        active_q <= 1'b0;
      end
      sh_q <= sh_q << 1;
      bit_q <= bit_q + 7'h1;
    end
    else if (expired && !fall && !rise)
    begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.data_line <= 1'b1;
    end
    else if (rise && active_q)
    begin
      link.data_line <= (bit_q == 7'(W)) ? 1'b0 : sh_q[W-1];
    end
    else if (expired && !active_q)
    begin
      link.data_line <= 1'b1;
    end
  end
endmodule

// *** design/ssi_master.sv ***
// SSI master with an APB register slave.
// Assumes the encoder end on the other side of ssi_link_if.
`timescale 1ns/100ps
`include "ssi_params.svh"
module ssi_master
#(
  parameter int ST_W = 14,
  parameter int MT_W = 24,
  parameter bit GRAY = 1'b1,
  parameter int unsigned SET_HOLD_CYC = `SSI_SET_HOLD_CYC,
  parameter int unsigned POWERUP_CYC = `SSI_POWERUP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssi_link_if.master link
);
  localparam int W = MT_W + ST_W;

  function automatic logic [W-1:0] gray2bin(input logic [W-1:0] g);
    logic [W-1:0] b;
    b[W-1] = g[W-1];
    for (int i = W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic d_s1_q;
  logic d_s2_q;
  logic [15:0] div_q;
  logic done_q;
  logic ready_q;
  logic [31:0] pu_cnt_q;
  logic [31:0] hold_q;
  logic [W-1:0] rx_q;
  logic [ST_W-1:0] pos_st_q;
  logic [MT_W-1:0] pos_mt_q;
  ssi_pkg::mstate_e st_q;
  logic [15:0] half_q;
  logic [6:0] fall_q;
  logic wr;
  logic wr_ctrl;
  logic start;
  logic burst_end;

  assign wr = psel & penable & pready & pwrite;
  assign wr_ctrl = wr && paddr == `SSI_REG_CTRL;
  assign start = wr_ctrl && pwdata[`SSI_CTRL_START] && ready_q && st_q == ssi_pkg::M_IDLE;
  assign burst_end = st_q == ssi_pkg::M_HIGH && half_q == div_q - 16'h1 && fall_q == 7'(W + 1);

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        unique case (paddr)
          `SSI_REG_CTRL: prdata <= 32'({link.dir_line, link.preset_line, 1'b0});
          `SSI_REG_DIV: prdata <= 32'(div_q);
          `SSI_REG_STATUS: prdata <= 32'({link.preset_line, ready_q, done_q,
                                          st_q != ssi_pkg::M_IDLE});
          `SSI_REG_POS_ST: prdata <= 32'(pos_st_q);
          `SSI_REG_POS_MT: prdata <= 32'(pos_mt_q);
          default:
          begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= `SSI_DIV_RST;
    end
    else if (wr && paddr == `SSI_REG_DIV)
    begin
      if (pwdata[15:0] < 16'(`SSI_HALF_MIN))
        div_q <= 16'(`SSI_HALF_MIN);
      else if (pwdata[15:0] > 16'(`SSI_HALF_MAX))
        div_q <= 16'(`SSI_HALF_MAX);
      else
        div_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
    end
    else if (burst_end)
    begin
      done_q <= 1'b1;
    end
    else if (wr && paddr == `SSI_REG_STATUS && pwdata[`SSI_ST_DONE])
    begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-up wait, preset pulse and direction level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pu_cnt_q <= 32'h0;
      ready_q <= 1'b0;
    end
    else if (pu_cnt_q == 32'(POWERUP_CYC - 1))
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      pu_cnt_q <= pu_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.preset_line <= 1'b0;
      hold_q <= 32'h0;
    end
    else if (!link.preset_line && wr_ctrl && pwdata[`SSI_CTRL_SET])
    begin
      link.preset_line <= 1'b1;
      hold_q <= 32'h0;
    end
    else if (link.preset_line)
    begin
      if (hold_q == 32'(SET_HOLD_CYC - 1))
        link.preset_line <= 1'b0;
      hold_q <= hold_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link.dir_line <= 1'b0;
    else if (wr_ctrl)
      link.dir_line <= pwdata[`SSI_CTRL_DIR];
  end

  ////////////////////////////////////////////////////////////////////
  // Burst engine: W+1 clock pulses, data taken on falls 2..W+1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d_s1_q <= 1'b1;
      d_s2_q <= 1'b1;
    end
    else
    begin
      d_s1_q <= link.data_line;
      d_s2_q <= d_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ssi_pkg::M_IDLE;
      link.clk_line <= 1'b1;
      half_q <= 16'h0;
      fall_q <= 7'h0;
      rx_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ssi_pkg::M_IDLE:
        begin
          if (start)
          begin
            st_q <= ssi_pkg::M_LOW;
            link.clk_line <= 1'b0;
            half_q <= 16'h0;
            fall_q <= 7'h1;
          end
        end
        ssi_pkg::M_LOW:
        begin
          half_q <= half_q + 16'h1;
          if (half_q == div_q - 16'h1)
          begin
            st_q <= ssi_pkg::M_HIGH;
            link.clk_line <= 1'b1;
            half_q <= 16'h0;
          end
        end
        ssi_pkg::M_HIGH:
        begin
          half_q <= half_q + 16'h1;
          if (burst_end)
          begin
            st_q <= ssi_pkg::M_IDLE;
          end
          else if (half_q == div_q - 16'h1)
          begin
            st_q <= ssi_pkg::M_LOW;
            link.clk_line <= 1'b0;
            half_q <= 16'h0;
            fall_q <= fall_q + 7'h1;
            rx_q <= {rx_q[W-2:0], d_s2_q};
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_st_q <= '0;
      pos_mt_q <= '0;
    end
    else if (burst_end)
    begin
      {pos_mt_q, pos_st_q} <= GRAY ? gray2bin(rx_q) : rx_q;
    end
  end
endmodule

// *** shared/ssi_link_if.sv ***
// Point-to-point SSI link plus the encoder's preset and direction pins.
// All wires are one-way; no wire is shared by two drivers.
`timescale 1ns/100ps
interface ssi_link_if;
  logic clk_line;
  logic data_line;
  logic preset_line;
  logic dir_line;
  modport encoder (input clk_line, input preset_line, input dir_line, output data_line);
  modport master (output clk_line, output preset_line, output dir_line, input data_line);
endinterface

// *** shared/ssi_params.svh ***
// Timing counts, register offsets and reset values for the SSI link.
// Assumes a 125 MHz pclk; cycle counts are derived from that rate.
// Summary of operation
// - Singleturn 10..14 bits, multiturn up to 24
// - Word sent Gray or binary, fixed
// - Link clock 50 kHz..2 MHz, sample every 2 ms
// - Burst inside monoflop repeats previous word
// - Burst after monoflop sends fresh sample
// - High preset input zeroes current position
// - Controller holds preset high 10 ms minimum
// - Preset visible on link after 1 ms
// - Preset commit phase lasts 200 ms
// - Preset value zero by default, build option
// - Preset only while shaft stands still
// - High direction input reverses counting sense
// - Build option inverts direction input effect
// - Direction change effective within 1 ms
// - Position valid only 150 ms after power-up
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH
`define SSI_CLK_MHZ 125
`define SSI_MONOFLOP_NS 15000
`define SSI_MONOFLOP_CYC ((`SSI_MONOFLOP_NS * `SSI_CLK_MHZ) / 1000)
`define SSI_REFRESH_US 2000
`define SSI_REFRESH_CYC (`SSI_REFRESH_US * `SSI_CLK_MHZ)
`define SSI_SET_DELAY_US 1000
`define SSI_SET_DELAY_CYC (`SSI_SET_DELAY_US * `SSI_CLK_MHZ)
`define SSI_SET_PROC_MS 200
`define SSI_SET_PROC_CYC (`SSI_SET_PROC_MS * `SSI_CLK_MHZ * 1000)
`define SSI_SET_HOLD_MS 10
`define SSI_SET_HOLD_CYC (`SSI_SET_HOLD_MS * `SSI_CLK_MHZ * 1000)
`define SSI_DIR_RESP_US 1000
`define SSI_DIR_RESP_CYC (`SSI_DIR_RESP_US * `SSI_CLK_MHZ)
`define SSI_POWERUP_MS 150
`define SSI_POWERUP_CYC (`SSI_POWERUP_MS * `SSI_CLK_MHZ * 1000)
`define SSI_FMAX_KHZ 2000
`define SSI_FMIN_KHZ 50
`define SSI_HALF_MIN ((`SSI_CLK_MHZ * 1000 + 2 * `SSI_FMAX_KHZ - 1) / (2 * `SSI_FMAX_KHZ))
`define SSI_HALF_MAX ((`SSI_CLK_MHZ * 1000) / (2 * `SSI_FMIN_KHZ))
`define SSI_REG_CTRL 8'h00
`define SSI_REG_DIV 8'h04
`define SSI_REG_STATUS 8'h08
`define SSI_REG_POS_ST 8'h0c
`define SSI_REG_POS_MT 8'h10
`define SSI_CTRL_START 0
`define SSI_CTRL_SET 1
`define SSI_CTRL_DIR 2
`define SSI_ST_BUSY 0
`define SSI_ST_DONE 1
`define SSI_ST_READY 2
`define SSI_ST_SET 3
`define SSI_DIV_RST 16'h003f
`endif

// *** shared/ssi_pkg.sv ***
// Types used by the master end of the SSI link.
package ssi_pkg;
  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} mstate_e;
endpackage

// *** sim/ssi_link_sva.sv ***
// Concurrent checks on the SSI link wires between master and encoder.
// Assumes one pclk domain; HALF_CYC is the half period set by the bench.
`timescale 1ns/100ps
`include "ssi_params.svh"
module ssi_link_sva
#(
  parameter int ST_W = 14,
  parameter int MT_W = 24,
  parameter int HALF_CYC = 32,
  parameter int unsigned SET_HOLD_CYC = `SSI_SET_HOLD_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_line,
  input wire logic data_line,
  input wire logic preset_line,
  input wire logic dir_line
);
  logic [11:0] low_cnt_q;
  logic [11:0] high_cnt_q;
  logic [7:0] falls_q;
  logic [31:0] set_cnt_q;
  ////////////////////////////////////////
  // Saturating level counters
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt_q <= 12'h0;
    else if (clk_line) low_cnt_q <= 12'h0;
    else if (low_cnt_q != 12'hfff) low_cnt_q <= low_cnt_q + 12'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) high_cnt_q <= 12'h0;
    else if (!clk_line) high_cnt_q <= 12'h0;
    else if (high_cnt_q != 12'hfff) high_cnt_q <= high_cnt_q + 12'h1;
  // Falls of one burst; cleared once the line has idled past a half period
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) falls_q <= 8'h0;
    else if (high_cnt_q == 12'(HALF_CYC + 8)) falls_q <= 8'h0;
    else if ($fell(clk_line)) falls_q <= falls_q + 8'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) set_cnt_q <= 32'h0;
    else if (!preset_line) set_cnt_q <= 32'h0;
    else if (set_cnt_q != 32'hffffffff) set_cnt_q <= set_cnt_q + 32'h1;
  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_idle_a: assert property ($rose(presetn) |-> clk_line && data_line
    && !preset_line && !dir_line) else $error("link not idle after reset");
  clk_low_min_a: assert property ($rose(clk_line) |-> low_cnt_q >= `SSI_HALF_MIN)
    else $error("link clock low half too short");
  clk_high_min_a: assert property ($fell(clk_line) |-> high_cnt_q >= `SSI_HALF_MIN)
    else $error("link clock high half too short");
  clk_low_max_a: assert property (!clk_line |-> low_cnt_q < `SSI_HALF_MAX)
    else $error("link clock low half too long");
  data_hold_a: assert property (!clk_line && !$past(clk_line) |-> $stable(data_line))
    else $error("data changed while clock low");
  idle_high_a: assert property (high_cnt_q > 12'd1900 |-> data_line)
    else $error("data not high after monoflop");
  burst_len_a: assert property (high_cnt_q == 12'(HALF_CYC + 8) |->
    falls_q == 8'h0 || falls_q == 8'(ST_W + MT_W + 1)) else $error("wrong burst length");
  set_hold_a: assert property ($fell(preset_line) |-> set_cnt_q >= SET_HOLD_CYC)
    else $error("preset pulse too short");
endmodule

// *** sim/testbench.sv ***
// Bench joining master and encoder over ssi_link_if; APB driven here.
// Assumes shortened counts (power-up 100, refresh 200) and half period 32.
`timescale 1ns/100ps
`include "ssi_params.svh"
module testbench;
  localparam int ST_W = 10;
  localparam int MT_W = 12;
  localparam int W = ST_W + MT_W;
  // Shortened counts so that every phase fits a short run
  localparam int unsigned PU_CYC = 100;
  localparam int unsigned REF_CYC = 200;
  localparam int unsigned DLY_CYC = 50;
  localparam int unsigned PROC_CYC = 300;
  localparam int unsigned DIRR_CYC = 50;
  localparam int unsigned HOLD_CYC = 100;
  localparam int HALF_CYC = 32;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic pos_valid;
  logic set_busy;
  logic dir_sel;
  logic [W-1:0] raw_pos;
  logic [W-1:0] pos_a;
  logic [64:0] note;
  logic [64:0] notes[$];
  int mismatches;
  int comparisons;
  int seed;
  ssi_link_if link();
  ssi_encoder #(.ST_W(ST_W), .MT_W(MT_W), .REFRESH_CYC(REF_CYC), .SET_DELAY_CYC(DLY_CYC),
    .SET_PROC_CYC(PROC_CYC), .DIR_RESP_CYC(DIRR_CYC), .POWERUP_CYC(PU_CYC)) u_ssi_encoder
  (
    .pclk(pclk), .presetn(presetn), .link(link), .raw_pos(raw_pos),
    .pos_valid(pos_valid), .set_busy(set_busy)
  );
  ssi_master #(.ST_W(ST_W), .MT_W(MT_W), .SET_HOLD_CYC(HOLD_CYC), .POWERUP_CYC(PU_CYC))
    u_ssi_master
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link)
  );
  ssi_link_sva #(.ST_W(ST_W), .MT_W(MT_W), .HALF_CYC(HALF_CYC), .SET_HOLD_CYC(HOLD_CYC))
    u_link_sva
  (
    .pclk(pclk), .presetn(presetn), .clk_line(link.clk_line), .data_line(link.data_line),
    .preset_line(link.preset_line), .dir_line(link.dir_line)
  );
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Note holds {slave error, read mask, expected or write data}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic err);
    notes.push_back({err, m, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One burst, then the decoded position halves are read back
  task automatic sample(input logic [W-1:0] exp);
    apb(1'b1, `SSI_REG_CTRL, {29'h0, dir_sel, 2'b01}, 32'h0, 1'b0);
    do apb(1'b0, `SSI_REG_STATUS, 32'h0, 32'h0, 1'b0); while (rd[`SSI_ST_DONE] !== 1'b1);
    apb(1'b1, `SSI_REG_STATUS, 32'h2, 32'h0, 1'b0);
    apb(1'b0, `SSI_REG_STATUS, 32'h0, 32'h2, 1'b0);
    apb(1'b0, `SSI_REG_POS_ST, 32'(exp[ST_W-1:0]), (32'h1 << ST_W) - 32'h1, 1'b0);
    apb(1'b0, `SSI_REG_POS_MT, 32'(exp[W-1:ST_W]), (32'h1 << MT_W) - 32'h1, 1'b0);
  endtask
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      note = notes.pop_front();
      cmp_flag(pslverr, note[64]);
      if (note[63:32] != 32'h0) cmp_word(prdata & note[63:32], note[31:0]);
    end
  ////////////////////////////////////////
  initial
  begin
    seed = 32'hc679c8a4;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    dir_sel = 1'b0;
    raw_pos = W'($random(seed));
    wait_cyc(12);
    presetn <= 1'b1;
    apb(1'b0, `SSI_REG_DIV, 32'h3f, 32'hffff, 1'b0);
    apb(1'b0, `SSI_REG_STATUS, 32'h0, 32'h4, 1'b0);
    cmp_flag(pos_valid, 1'b0);
    apb(1'b1, `SSI_REG_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `SSI_REG_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 8'h3c, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, `SSI_REG_DIV, 32'h5, 32'h0, 1'b0);
    apb(1'b0, `SSI_REG_DIV, 32'h20, 32'hffff, 1'b0);
    while (pos_valid !== 1'b1) @(posedge pclk);
    wait_cyc(300);
    apb(1'b0, `SSI_REG_STATUS, 32'h4, 32'h4, 1'b0);
    pos_a = raw_pos;
    sample(pos_a);
    raw_pos <= W'($random(seed));
    wait_cyc(250);
    sample(pos_a);
    wait_cyc(2000);
    sample(raw_pos);
    dir_sel = 1'b1;
    apb(1'b1, `SSI_REG_CTRL, 32'h4, 32'h0, 1'b0);
    apb(1'b0, `SSI_REG_CTRL, 32'h4, 32'h4, 1'b0);
    wait_cyc(2000);
    sample(-raw_pos);
    dir_sel = 1'b0;
    apb(1'b1, `SSI_REG_CTRL, 32'h0, 32'h0, 1'b0);
    wait_cyc(100);
    apb(1'b1, `SSI_REG_CTRL, 32'h2, 32'h0, 1'b0);
    wait_cyc(120);
    cmp_flag(set_busy, 1'b1);
    wait_cyc(2000);
    cmp_flag(set_busy, 1'b0);
    sample('0);
    raw_pos <= raw_pos + W'(5);
    wait_cyc(2000);
    sample(W'(5));
    stop_test();
  end
  initial
  begin
    wait_cyc(60000);
    mismatches++;
    stop_test();
  end
endmodule
